// *** core/flash_power_saving_modes.sv ***
// power-saving controller: clock stop during read and deep sleep entry and exit
// Notes on behaviour
// RQ1: during read output, enter clock-stop on its own once the bus clock holds still for 30 ns.
// RQ2: in clock-stop the current output byte stays latched and driven.
// RQ3: clock-stop is entered even while chip select stays low.
// RQ4: a toggling clock ends clock-stop and normal read resumes.
// RQ5: program or erase keeps running regardless of clock-stop.
// RQ6: the host requests deep sleep only from standby and with no overlay active.
// RQ7: writing zero to the sleep request bit starts entry, and sleep is reached no sooner than 10 us later.
// RQ8: during entry chip select is ignored and no transaction is processed.
// RQ9: no command during entry interrupts or aborts it.
// RQ10: the host wakes the device by repeating the sleep command, only after entry has finished.
// RQ11: during wake-up commands are ignored, nothing is processed, and the read strobe stays still.
// RQ12: a reset pulse of the least width ends deep sleep and standby follows within 300 us.
// RQ13: a reset pulse of the least width during entry cancels the entry.
// RQ14: on leaving deep sleep all volatile settings reload to their power-on defaults.
// RQ15: entry, wake-up and clock-stop intervals are timed on the internal clock.
`timescale 1ns/1ps
module flash_power_saving_modes #(
  parameter int unsigned ENTRY_CYC = power_modes_pkg::SLEEP_ENTRY_CYC,
  parameter int unsigned WAKE_CYC = power_modes_pkg::SLEEP_WAKE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic bus_clk_in,
  input wire logic chip_select_n_in,
  input wire logic read_data_phase_in,
  input wire logic [7:0] read_byte_in,
  input wire logic read_strobe_in,
  input wire logic reset_pin_n_in,
  input wire logic cfg_write_in,
  input wire logic [15:0] cfg_data_in,
  input wire logic sleep_command_in,
  input wire logic overlay_active_in,
  input wire logic algorithm_busy_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic read_data_strobe_out,
  output logic clock_stop_out,
  output logic transactions_enabled_out,
  output logic deep_sleep_mode_out,
  output logic defaults_reload_out,
  output logic algorithm_run_out
);
  typedef enum logic [1:0] {ST_STANDBY, ST_ENTRY, ST_SLEEP, ST_WAKE} sleep_state_t;
  typedef struct packed {
    sleep_state_t st;
    logic bus_clk_prev;
    logic [7:0] still_cnt;
    logic [7:0] rst_cnt;
    logic clock_stop;
    logic [7:0] data;
    logic data_oe;
    logic strobe;
    logic enabled;
    logic sleep;
    logic reload;
    logic alg_run;
  } ctrl_state_t;
  ctrl_state_t cur_ff;
  ctrl_state_t nxt_cur;
  logic timer_start;
  logic [power_modes_pkg::CNT_W-1:0] timer_len;
  logic timer_done;
  logic reset_pulse_seen;

  // refuse intervals the timer or the 8-bit counters cannot hold
  if (ENTRY_CYC < 2 || ENTRY_CYC >= (1 << power_modes_pkg::CNT_W)) begin : g_entry_range
    $error("ENTRY_CYC out of range");
  end
  if (WAKE_CYC < 2 || WAKE_CYC >= (1 << power_modes_pkg::CNT_W)) begin : g_wake_range
    $error("WAKE_CYC out of range");
  end
  if (power_modes_pkg::RESET_PULSE_CYC > 255 || power_modes_pkg::CLOCK_STOP_CYC > 255) begin : g_count_range
    $error("pulse or stop count too wide");
  end

  // RQ15 internal timebase
  interval_timer #(.WIDTH(power_modes_pkg::CNT_W)) u_timer (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .start_in(timer_start),
    .length_in(timer_len),
    .done_out(timer_done)
  );

  // a reset pulse counts only once it has been low for the least width
  assign reset_pulse_seen = (cur_ff.rst_cnt == 8'(power_modes_pkg::RESET_PULSE_CYC)) && reset_pin_n_in;

  always_comb begin
    nxt_cur = cur_ff;
    timer_start = 1'b0;
    timer_len = '0;
    nxt_cur.reload = 1'b0;
    nxt_cur.bus_clk_prev = bus_clk_in;
    if (!reset_pin_n_in) begin
      if (cur_ff.rst_cnt != 8'(power_modes_pkg::RESET_PULSE_CYC)) begin
        nxt_cur.rst_cnt = cur_ff.rst_cnt + 8'h01;
      end
    end else begin
      nxt_cur.rst_cnt = 8'h00;
    end
    // RQ5 algorithm independent
    nxt_cur.alg_run = algorithm_busy_in;
    // RQ1 still clock count
    if (bus_clk_in != cur_ff.bus_clk_prev || !read_data_phase_in || cur_ff.st != ST_STANDBY) begin
      nxt_cur.still_cnt = 8'h00;
    end else if (cur_ff.still_cnt != 8'(power_modes_pkg::CLOCK_STOP_CYC)) begin
      nxt_cur.still_cnt = cur_ff.still_cnt + 8'h01;
    end
    // RQ3 chip select not consulted
    if (cur_ff.st == ST_STANDBY && read_data_phase_in) begin
      // RQ4 toggling clock resumes
      nxt_cur.clock_stop = (nxt_cur.still_cnt == 8'(power_modes_pkg::CLOCK_STOP_CYC));
    end else begin
      nxt_cur.clock_stop = 1'b0;
    end
    // RQ2 byte held in clock-stop
    if (cur_ff.st == ST_STANDBY && read_data_phase_in && !chip_select_n_in) begin
      if (!nxt_cur.clock_stop) begin
        nxt_cur.data = read_byte_in;
        nxt_cur.strobe = read_strobe_in;
      end
      nxt_cur.data_oe = 1'b1;
    end else begin
      nxt_cur.data_oe = 1'b0;
      nxt_cur.strobe = 1'b0;
    end
    if (!reset_pin_n_in) begin
      nxt_cur.data_oe = 1'b0;
    end
    unique case (cur_ff.st)
      ST_STANDBY: begin
        nxt_cur.enabled = reset_pin_n_in;
        // RQ7 sleep bit cleared
        if (reset_pin_n_in && cfg_write_in && !cfg_data_in[power_modes_pkg::SLEEP_REQ_BIT] && !overlay_active_in) begin
          nxt_cur.st = ST_ENTRY;
          nxt_cur.enabled = 1'b0;
          timer_start = 1'b1;
          timer_len = power_modes_pkg::CNT_W'(ENTRY_CYC);
        end
      end
      ST_ENTRY: begin
        // RQ8 RQ9 inputs ignored
        nxt_cur.enabled = 1'b0;
        // RQ13 reset cancels entry
        if (reset_pulse_seen) begin
          nxt_cur.st = ST_STANDBY;
          nxt_cur.enabled = 1'b1;
          nxt_cur.reload = 1'b1;
        end else if (timer_done) begin
          nxt_cur.st = ST_SLEEP;
          nxt_cur.sleep = 1'b1;
        end
      end
      ST_SLEEP: begin
        // RQ10 RQ12 exit paths
        if (sleep_command_in || reset_pulse_seen) begin
          nxt_cur.st = ST_WAKE;
          timer_start = 1'b1;
          timer_len = power_modes_pkg::CNT_W'(WAKE_CYC);
        end
      end
      ST_WAKE: begin
        // RQ11 strobe quiet while waking
        nxt_cur.enabled = 1'b0;
        if (timer_done) begin
          nxt_cur.st = ST_STANDBY;
          nxt_cur.sleep = 1'b0;
          nxt_cur.enabled = 1'b1;
          // RQ14 defaults reloaded
          nxt_cur.reload = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cur_ff <= '{st: ST_STANDBY, bus_clk_prev: 1'b0, still_cnt: 8'h00, rst_cnt: 8'h00, clock_stop: 1'b0,
                  data: power_modes_pkg::DATA_RESET, data_oe: 1'b0, strobe: 1'b0, enabled: 1'b0,
                  sleep: 1'b0, reload: 1'b0, alg_run: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign data_out = cur_ff.data;
  assign data_oe_out = cur_ff.data_oe;
  assign read_data_strobe_out = cur_ff.strobe;
  assign clock_stop_out = cur_ff.clock_stop;
  assign transactions_enabled_out = cur_ff.enabled;
  assign deep_sleep_mode_out = cur_ff.sleep;
  assign defaults_reload_out = cur_ff.reload;
  assign algorithm_run_out = cur_ff.alg_run;

  property p_stop_holds_byte;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (clock_stop_out && $past(clock_stop_out)) |-> $stable(data_out);
  endproperty
  a_stop_holds_byte: assert property (p_stop_holds_byte) else $error("byte changed in clock stop"); // RQ2

  property p_toggle_ends_stop;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (clock_stop_out && bus_clk_in != cur_ff.bus_clk_prev) |=> !clock_stop_out;
  endproperty
  a_toggle_ends_stop: assert property (p_toggle_ends_stop) else $error("clock stop kept after toggle"); // RQ4

  property p_alg_follows;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    1'b1 |=> algorithm_run_out == $past(algorithm_busy_in);
  endproperty
  a_alg_follows: assert property (p_alg_follows) else $error("algorithm run gated"); // RQ5

  sequence s_entry_start;
    cur_ff.st == ST_STANDBY && nxt_cur.st == ST_ENTRY;
  endsequence
  property p_entry_blocks;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_entry_start |=> !transactions_enabled_out [*2];
  endproperty
  a_entry_blocks: assert property (p_entry_blocks) else $error("transactions during entry"); // RQ8

  property p_entry_not_early;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_entry_start |=> !deep_sleep_mode_out [*8];
  endproperty
  a_entry_not_early: assert property (p_entry_not_early) else $error("sleep reached too soon"); // RQ7

  property p_cmd_no_abort;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (cur_ff.st == ST_ENTRY && sleep_command_in && !reset_pulse_seen) |=> cur_ff.st != ST_STANDBY;
  endproperty
  a_cmd_no_abort: assert property (p_cmd_no_abort) else $error("command aborted entry"); // RQ9

  property p_wake_quiet;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (cur_ff.st == ST_WAKE) |-> !read_data_strobe_out && !data_oe_out;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("strobe moved in wake"); // RQ11

  property p_reset_cancel;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    (cur_ff.st == ST_ENTRY && reset_pulse_seen) |=> cur_ff.st == ST_STANDBY && defaults_reload_out;
  endproperty
  a_reset_cancel: assert property (p_reset_cancel) else $error("reset did not cancel entry"); // RQ13

  property p_wake_reload;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    $fell(deep_sleep_mode_out) |-> defaults_reload_out && transactions_enabled_out;
  endproperty
  a_wake_reload: assert property (p_wake_reload) else $error("no reload on wake"); // RQ14
endmodule : flash_power_saving_modes

// *** core/power_modes_pkg.sv ***
// constants for the flash interface power-saving controller
package power_modes_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // clock-stop detect time in ns, least time so round up
  localparam int unsigned CLOCK_STOP_NS = 30;
  localparam int unsigned CLOCK_STOP_CYC = (CLOCK_STOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // sleep entry least time in us, round up
  localparam int unsigned SLEEP_ENTRY_US = 10;
  localparam int unsigned SLEEP_ENTRY_CYC = (SLEEP_ENTRY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // wake longest time in us, round down
  localparam int unsigned SLEEP_WAKE_US = 300;
  localparam int unsigned SLEEP_WAKE_CYC = (SLEEP_WAKE_US * 1000000) / CLK_PERIOD_PS;
  // reset pulse least width in ns, round up
  localparam int unsigned RESET_PULSE_NS = 200;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int unsigned SLEEP_REQ_BIT = 15;
endpackage : power_modes_pkg

// *** core/interval_timer.sv ***
// one-shot timebase counter that flags when a loaded interval has elapsed
`timescale 1ns/1ps
module interval_timer #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] length_in,
  output logic done_out
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic running;
    logic done;
  } timer_state_t;
  timer_state_t cur_ff;
  timer_state_t nxt_cur;

  if (WIDTH < 2) begin : g_width_check
    $error("WIDTH too small");
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    if (start_in) begin
      nxt_cur.count = length_in;
      nxt_cur.running = 1'b1;
    end else if (cur_ff.running) begin
      if (cur_ff.count <= WIDTH'(1)) begin
        nxt_cur.running = 1'b0;
        nxt_cur.done = 1'b1;
      end else begin
        nxt_cur.count = cur_ff.count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign done_out = cur_ff.done;
endmodule : interval_timer

// *** dv/host_bus_model.sv ***
// host bus controller model: bus clock, chip select and sleep requests
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_sys_in,
  input wire logic run_in,
  input wire logic select_in,
  input wire logic sleep_req_in,
  input wire logic wake_req_in,
  input wire logic enabled_in,
  input wire logic overlay_in,
  input wire logic deep_sleep_in,
  output logic bus_clk_out,
  output logic chip_select_n_out,
  output logic cfg_write_out,
  output logic [15:0] cfg_data_out,
  output logic sleep_command_out
);
  logic bus_clk_ff = 1'h0;
  logic cfg_write_ff = 1'h0;
  logic sleep_command_ff = 1'h0;
  assign bus_clk_out = bus_clk_ff;
  assign cfg_write_out = cfg_write_ff;
  assign sleep_command_out = sleep_command_ff;
  assign chip_select_n_out = ~select_in;
  // idle pattern keeps the request bit high so a stray write never requests sleep
  assign cfg_data_out = cfg_write_ff ? 16'h7FFF : 16'hFFFF;
  // clock stands still while the transfer is paused
  always @(posedge clk_sys_in) begin
    if (run_in) begin
      bus_clk_ff <= ~bus_clk_ff;
    end
    cfg_write_ff <= sleep_req_in & enabled_in & ~overlay_in;
    sleep_command_ff <= wake_req_in & deep_sleep_in;
  end
endmodule : host_bus_model

// *** dv/tb_top.sv ***
// self-checking bench for the power-saving controller
`timescale 1ns/1ps
module tb_top;
  localparam int ENTRY = 60;
  localparam int WAKE = 30;
  localparam int PULSE = power_modes_pkg::RESET_PULSE_CYC + 1;
  localparam int STOP = power_modes_pkg::CLOCK_STOP_CYC;
  logic clk_sys_in = 1'h0, arst_n_in = 1'h0, run = 1'h0, sel = 1'h0, sreq = 1'h0, wreq = 1'h0;
  logic raw_wr = 1'h0, raw_cmd = 1'h0, in_wake = 1'h0, rd_phase = 1'h0, rd_strobe = 1'h0;
  logic rst_pin_n = 1'h1, overlay = 1'h0, alg_busy = 1'h0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] data_out;
  logic [15:0] m_data;
  logic bus_clk, cs_n, m_wr, m_cmd, data_oe, strobe, cstop, enabled, dsleep, reload, arun;
  int err_count = 0;
  int num_checks = 0;
  int n;
  logic held;
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) #1 rd_strobe = ~rd_strobe;
  host_bus_model host (.clk_sys_in(clk_sys_in), .run_in(run), .select_in(sel), .sleep_req_in(sreq),
    .wake_req_in(wreq), .enabled_in(enabled), .overlay_in(overlay), .deep_sleep_in(dsleep),
    .bus_clk_out(bus_clk), .chip_select_n_out(cs_n), .cfg_write_out(m_wr), .cfg_data_out(m_data),
    .sleep_command_out(m_cmd));
  flash_power_saving_modes #(.ENTRY_CYC(ENTRY), .WAKE_CYC(WAKE)) dut (.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .bus_clk_in(bus_clk), .chip_select_n_in(cs_n), .read_data_phase_in(rd_phase),
    .read_byte_in(rd_byte), .read_strobe_in(rd_strobe), .reset_pin_n_in(rst_pin_n),
    .cfg_write_in(m_wr | raw_wr), .cfg_data_in(raw_wr ? 16'h7FFF : m_data), .sleep_command_in(m_cmd | raw_cmd),
    .overlay_active_in(overlay), .algorithm_busy_in(alg_busy), .data_out(data_out), .data_oe_out(data_oe),
    .read_data_strobe_out(strobe), .clock_stop_out(cstop), .transactions_enabled_out(enabled),
    .deep_sleep_mode_out(dsleep), .defaults_reload_out(reload), .algorithm_run_out(arun));
  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask : step
  function automatic logic pick(input int s);
    case (s)
      0: return cstop;
      1: return dsleep;
      default: return reload;
    endcase
  endfunction : pick
  // bounded wait; cnt is the number of edges passed
  task automatic wait_for(input int s, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(s) !== v) begin
      if (cnt == lim) begin
        err_count++;
        $display("ERROR t=%0t wait %h got=%h exp=%h", $time, s, pick(s), v);
        results();
      end
      step(1);
      cnt++;
    end
  endtask : wait_for
  // sampled mid-cycle so registered outputs have settled
  always @(negedge clk_sys_in) if (in_wake) check({strobe, enabled, data_oe}, 3'h0);
  initial begin
    step(20);
    arst_n_in = 1'h1;
    step(3);
    check({enabled, dsleep, cstop}, 3'h4);
    $display("test reset done");
    rd_phase = 1'h1; sel = 1'h1; run = 1'h1; rd_byte = 8'hA5; alg_busy = 1'h1;
    step(6);
    run = 1'h0;
    wait_for(0, 1'h1, 12, n);
    check(n >= STOP && n <= STOP + 3, 1'h1);
    rd_byte = 8'h3C;
    step(2);
    check(data_out, 8'hA5);
    check({data_oe, arun}, 2'h3);
    held = strobe;
    step(1);
    check(strobe, held);
    run = 1'h1;
    step(3);
    check({cstop, data_out}, 9'h03C);
    rd_phase = 1'h0; sel = 1'h0; run = 1'h0; alg_busy = 1'h0;
    $display("test clock stop done");
    overlay = 1'h1; raw_wr = 1'h1;
    step(1);
    raw_wr = 1'h0;
    step(3);
    check(enabled, 1'h1);
    overlay = 1'h0;
    sreq = 1'h1;
    step(1);
    sreq = 1'h0;
    step(2);
    check(enabled, 1'h0);
    raw_cmd = 1'h1; sel = 1'h1;
    step(1);
    raw_cmd = 1'h0; sel = 1'h0;
    wait_for(1, 1'h1, ENTRY + 10, n);
    check(n + 2 >= ENTRY, 1'h1);
    rd_phase = 1'h1; sel = 1'h1; wreq = 1'h1;
    step(1);
    wreq = 1'h0; in_wake = 1'h1;
    wait_for(1, 1'h0, WAKE + 10, n);
    in_wake = 1'h0; rd_phase = 1'h0; sel = 1'h0;
    check({enabled, reload}, 2'h3);
    $display("test sleep by command done");
    sreq = 1'h1;
    step(1);
    sreq = 1'h0;
    step(3);
    rst_pin_n = 1'h0;
    step(PULSE);
    rst_pin_n = 1'h1;
    wait_for(2, 1'h1, 10, n);
    check(dsleep, 1'h0);
    step(2);
    check(enabled, 1'h1);
    sreq = 1'h1;
    step(1);
    sreq = 1'h0;
    wait_for(1, 1'h1, ENTRY + 10, n);
    check(n >= ENTRY + 1, 1'h1);
    rst_pin_n = 1'h0;
    step(PULSE);
    rst_pin_n = 1'h1;
    wait_for(1, 1'h0, WAKE + 10, n);
    check(n <= WAKE + 2, 1'h1);
    check({enabled, reload}, 2'h3);
    $display("test reset exits done");
    results();
  end
endmodule : tb_top
